// *** design/dpg_gpio.sv ***
// How it works
// RL1: First port bits: direction one floats the pin, zero drives latch.
// RL2: Reading first port gives pin levels; writing changes only the latch.
// RL3: Writes sample the pins, modify addressed bits, store into latch; here data writes store the whole byte, only set/clear use the pins.
// RL4: Clearing option bit 7 turns on all first-port pull-ups together.
// RL5: A pin set as output never has its pull-up on.
// RL6: Power-on reset leaves every first-port pull-up off.
// RL7: Only upper four input pins are compared for change.
// RL8: Upper inputs compared to last-read snapshot; any mismatch sets flag.
// RL9: A set change flag can wake the device from sleep.
// RL10: Mismatch keeps setting flag; software touches port, then clears it.
// RL11: A change exactly at a port read may not set the flag.
// RL12: Software should not poll first port while using change detection.
// RL13: Third port: eight latch bits with per-pin direction control.
// RL14: Third port reads pins, writes latch by read-modify-write; here only set/clear writes use the pins, data writes store the byte.
// RL15: Third direction resets to ones; latch unknown at power-on, kept else; here power-on loads LATCH_POR, 00.
// RL16: Change flag raises the interrupt only while its enable bit is set.
// RL17: Input pins pass two flip-flops before reads and comparison.
module dpg_gpio
#(
  parameter int WIDTH = dpg_pkg::PORT_W
)
(
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        power_on,
  input  wire logic [dpg_pkg::ADDR_W-1:0]  paddr,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dpg_pkg::DATA_W-1:0]  pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [dpg_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [WIDTH-1:0]            first_port_pins_in,
  output logic      [WIDTH-1:0]            first_port_pins_out,
  output logic      [WIDTH-1:0]            first_port_pins_oe_n,
  output logic      [WIDTH-1:0]            first_port_pullup_en,
  input  wire logic [WIDTH-1:0]            third_port_data_in,
  output logic      [WIDTH-1:0]            third_port_data_out,
  output logic      [WIDTH-1:0]            third_port_data_oe_n,
  output logic                             irq,
  output logic                             wake
);
  import dpg_pkg::*;

  generate
    if (WIDTH > PORT_W || WIDTH <= CHG_LO)
    begin : g_bad_width
      $error("dpg_gpio: WIDTH must be above CHG_LO and at most PORT_W");
    end
  endgenerate

  // Register fields and index width are tied to the bus layout
  generate
    if (IRQ_EN_BIT >= PORT_W || OPT_PULLUP_DIS_N_BIT >= PORT_W
        || ADDR_W != IDX_W + 2 || DATA_W < PORT_W)
    begin : g_bad_layout
      $error("dpg_gpio: register layout does not fit the bus");
    end
  endgenerate

  localparam int HI = WIDTH - 1;

  function automatic logic reg_hit
  (
    input logic [ADDR_W-1:0] addr,
    input logic [IDX_W-1:0]  idx
  );
    reg_hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx);
  endfunction

  // Latch update from sampled pins, as a bit-modify instruction would do
  function automatic logic [WIDTH-1:0] rmw
  (
    input logic [WIDTH-1:0] pins,
    input logic [WIDTH-1:0] wdata,
    input dpg_op_t          op
  );
    rmw = pins;
    unique case (op)
      DPG_OP_STORE: rmw = wdata;
      DPG_OP_SET:   rmw = pins | wdata;
      DPG_OP_CLR:   rmw = pins & ~wdata;
      default:      rmw = pins;
    endcase
  endfunction

  // Pin synchronisers
  logic [WIDTH-1:0] first_meta;
  logic [WIDTH-1:0] first_sync;
  logic [WIDTH-1:0] third_meta;
  logic [WIDTH-1:0] third_sync;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      first_meta <= '0;
      first_sync <= '0;
      third_meta <= '0;
      third_sync <= '0;
    end
    else
    begin
      first_meta <= first_port_pins_in; // RL17
      first_sync <= first_meta;         // RL17
      third_meta <= third_port_data_in; // RL17
      third_sync <= third_meta;         // RL17
    end
  end

  // Bus phase decode
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic wr_go;
  logic rd_go;

  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped    = reg_hit(paddr, IDX_FIRST_DATA)
                   || reg_hit(paddr, IDX_THIRD_DATA)
                   || reg_hit(paddr, IDX_IRQ_CTRL)
                   || reg_hit(paddr, IDX_FIRST_SET)
                   || reg_hit(paddr, IDX_FIRST_CLR)
                   || reg_hit(paddr, IDX_THIRD_SET)
                   || reg_hit(paddr, IDX_THIRD_CLR)
                   || reg_hit(paddr, IDX_OPTION)
                   || reg_hit(paddr, IDX_FIRST_DIR)
                   || reg_hit(paddr, IDX_THIRD_DIR);
  // Byte lane 0 carries every register; other lanes are ignored
  assign wr_go     = access_ph && pwrite && mapped && pstrb[0];
  assign rd_go     = access_ph && !pwrite && mapped;
  // Zero-wait slave
  assign pready    = access_ph;
  assign pslverr   = access_ph && !mapped;

  // Register state
  logic [WIDTH-1:0]     first_latch;
  logic [WIDTH-1:0]     first_dir;
  logic [WIDTH-1:0]     third_latch;
  logic [WIDTH-1:0]     third_dir;
  logic [PORT_W-1:0]    option_reg;
  logic [HI:CHG_LO]     snapshot;
  logic                 change_flag;
  logic                 change_irq_en;
  logic [DATA_W-1:0]    rd_data;

  logic [WIDTH-1:0]     next_first_latch;
  logic [WIDTH-1:0]     next_first_dir;
  logic [WIDTH-1:0]     next_third_latch;
  logic [WIDTH-1:0]     next_third_dir;
  logic [PORT_W-1:0]    next_option_reg;
  logic [HI:CHG_LO]     next_snapshot;
  logic                 next_change_flag;
  logic                 next_change_irq_en;
  logic [DATA_W-1:0]    next_rd_data;

  logic [WIDTH-1:0]     wbyte;
  logic                 mismatch;
  logic [PORT_W-1:0]    irq_ctrl_view;
  logic                 first_wr_hit;
  logic [HI:CHG_LO]     pin_diff;

  assign wbyte = pwdata[WIDTH-1:0];

  // Any write to the first port's data ends a pending mismatch
  assign first_wr_hit = reg_hit(paddr, IDX_FIRST_DATA)
                      || reg_hit(paddr, IDX_FIRST_SET)
                      || reg_hit(paddr, IDX_FIRST_CLR);

  // Output pins excluded; only inputs differing from snapshot count
  genvar ci;
  generate
    for (ci = CHG_LO; ci <= HI; ci++)
    begin : g_change
      assign pin_diff[ci] =
        (first_sync[ci] ^ snapshot[ci]) && first_dir[ci]; // RL7 RL8
    end
  endgenerate

  assign mismatch = |pin_diff; // RL8

  always_comb
  begin
    irq_ctrl_view               = '0;
    irq_ctrl_view[IRQ_FLAG_BIT] = change_flag;
    irq_ctrl_view[IRQ_EN_BIT]   = change_irq_en;
  end

  // Read data is captured in setup so it stands from flip-flops
  always_comb
  begin
    next_rd_data = rd_data;
    if (setup_ph && !pwrite)
    begin
      next_rd_data = '0;
      if (reg_hit(paddr, IDX_FIRST_DATA))
      begin
        next_rd_data[WIDTH-1:0] = first_sync; // RL2
      end
      else if (reg_hit(paddr, IDX_THIRD_DATA))
      begin
        next_rd_data[WIDTH-1:0] = third_sync; // RL14
      end
      else if (reg_hit(paddr, IDX_FIRST_DIR))
      begin
        next_rd_data[WIDTH-1:0] = first_dir;
      end
      else if (reg_hit(paddr, IDX_THIRD_DIR))
      begin
        next_rd_data[WIDTH-1:0] = third_dir;
      end
      else if (reg_hit(paddr, IDX_OPTION))
      begin
        next_rd_data[PORT_W-1:0] = option_reg;
      end
      else if (reg_hit(paddr, IDX_IRQ_CTRL))
      begin
        next_rd_data[PORT_W-1:0] = irq_ctrl_view;
      end
      else if (reg_hit(paddr, IDX_FIRST_SET)
               || reg_hit(paddr, IDX_FIRST_CLR))
      begin
        next_rd_data[WIDTH-1:0] = first_latch;
      end
      else if (reg_hit(paddr, IDX_THIRD_SET)
               || reg_hit(paddr, IDX_THIRD_CLR))
      begin
        next_rd_data[WIDTH-1:0] = third_latch;
      end
    end
  end

  always_comb
  begin
    next_first_latch   = first_latch;
    next_first_dir     = first_dir;
    next_third_latch   = third_latch;
    next_third_dir     = third_dir;
    next_option_reg    = option_reg;
    next_snapshot      = snapshot;
    next_change_flag   = change_flag;
    next_change_irq_en = change_irq_en;

    // Snapshot follows what software saw, ending the mismatch
    if (rd_go && reg_hit(paddr, IDX_FIRST_DATA))
    begin
      next_snapshot = rd_data[HI:CHG_LO]; // RL8 RL10
    end

    if (wr_go)
    begin
      // Set and clear writes start from the pins, so a driven pin held low by
      // a load can corrupt unaddressed bits; keep outputs unloaded.
      if (first_wr_hit)
      begin
        next_snapshot = first_sync[HI:CHG_LO]; // RL10
      end
      if (reg_hit(paddr, IDX_FIRST_DATA))
      begin
        next_first_latch = rmw(first_sync, wbyte, DPG_OP_STORE); // RL2 RL3
      end
      if (reg_hit(paddr, IDX_FIRST_SET))
      begin
        next_first_latch = rmw(first_sync, wbyte, DPG_OP_SET); // RL3
      end
      if (reg_hit(paddr, IDX_FIRST_CLR))
      begin
        next_first_latch = rmw(first_sync, wbyte, DPG_OP_CLR); // RL3
      end
      if (reg_hit(paddr, IDX_THIRD_DATA))
      begin
        next_third_latch = rmw(third_sync, wbyte, DPG_OP_STORE); // RL14
      end
      if (reg_hit(paddr, IDX_THIRD_SET))
      begin
        next_third_latch = rmw(third_sync, wbyte, DPG_OP_SET); // RL14
      end
      if (reg_hit(paddr, IDX_THIRD_CLR))
      begin
        next_third_latch = rmw(third_sync, wbyte, DPG_OP_CLR); // RL14
      end
      if (reg_hit(paddr, IDX_FIRST_DIR))
      begin
        next_first_dir = wbyte; // RL1
      end
      if (reg_hit(paddr, IDX_THIRD_DIR))
      begin
        next_third_dir = wbyte; // RL13
      end
      if (reg_hit(paddr, IDX_OPTION))
      begin
        next_option_reg = pwdata[PORT_W-1:0]; // RL4
      end
      if (reg_hit(paddr, IDX_IRQ_CTRL))
      begin
        next_change_irq_en = pwdata[IRQ_EN_BIT]; // RL16
        if (pwdata[IRQ_FLAG_BIT])
        begin
          next_change_flag = 1'b0;
        end
      end
    end

    // Set beats clear; a persisting mismatch keeps the flag up.
    // A change landing on the read edge still sets the flag: the
    // snapshot only takes pin values already compared in their cycle.
    if (mismatch)
    begin
      next_change_flag = 1'b1; // RL8 RL10 RL11
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      first_dir     <= DIR_RST;
      third_dir     <= DIR_RST;    // RL15
      option_reg    <= OPTION_RST; // RL6
      snapshot      <= '0;
      change_flag   <= FLAG_RST;
      change_irq_en <= IRQ_EN_RST;
      rd_data       <= '0;
      // Latches survive warm resets; only power-on gives a value
      if (power_on)
      begin
        first_latch <= LATCH_POR[WIDTH-1:0];
        third_latch <= LATCH_POR[WIDTH-1:0]; // RL15
      end
    end
    else
    begin
      first_latch   <= next_first_latch;
      first_dir     <= next_first_dir;
      third_latch   <= next_third_latch;
      third_dir     <= next_third_dir;
      option_reg    <= next_option_reg;
      snapshot      <= next_snapshot;
      change_flag   <= next_change_flag;
      change_irq_en <= next_change_irq_en;
      rd_data       <= next_rd_data;
    end
  end

  assign prdata = rd_data;

  // Pin drivers
  assign first_port_pins_out  = first_latch; // RL1
  assign first_port_pins_oe_n = first_dir;   // RL1
  assign third_port_data_out  = third_latch; // RL13
  assign third_port_data_oe_n = third_dir;   // RL13

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_pullup
      // Pull-up only on inputs, and only with the global enable low
      assign first_port_pullup_en[gi] =
        !option_reg[OPT_PULLUP_DIS_N_BIT] && first_dir[gi]; // RL4 RL5
    end
  endgenerate

  // Enable gates both the interrupt and the sleep wake-up
  assign irq  = change_flag && change_irq_en; // RL16
  assign wake = change_flag && change_irq_en; // RL9

endmodule

// *** design/dpg_pkg.sv ***
package dpg_pkg;

  // Port geometry
  localparam int PORT_W = 8;
  localparam int CHG_LO = 4;

  // APB geometry
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FIRST_DATA = 10'h006;
  localparam logic [IDX_W-1:0] IDX_THIRD_DATA = 10'h007;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTRL   = 10'h00b;
  localparam logic [IDX_W-1:0] IDX_FIRST_SET  = 10'h010;
  localparam logic [IDX_W-1:0] IDX_FIRST_CLR  = 10'h011;
  localparam logic [IDX_W-1:0] IDX_THIRD_SET  = 10'h012;
  localparam logic [IDX_W-1:0] IDX_THIRD_CLR  = 10'h013;
  localparam logic [IDX_W-1:0] IDX_OPTION     = 10'h081;
  localparam logic [IDX_W-1:0] IDX_FIRST_DIR  = 10'h086;
  localparam logic [IDX_W-1:0] IDX_THIRD_DIR  = 10'h087;

  // Field positions
  localparam int OPT_PULLUP_DIS_N_BIT = 7;
  localparam int IRQ_FLAG_BIT         = 0;
  localparam int IRQ_EN_BIT           = 3;

  // Reset values
  localparam logic [PORT_W-1:0] DIR_RST      = 8'hff;
  localparam logic [PORT_W-1:0] OPTION_RST   = 8'hff;
  localparam logic [PORT_W-1:0] LATCH_POR    = 8'h00;
  localparam logic              FLAG_RST     = 1'b0;
  localparam logic              IRQ_EN_RST   = 1'b0;

  // Kind of latch update
  typedef enum logic [1:0]
  {
    DPG_OP_STORE = 2'b00,
    DPG_OP_SET   = 2'b01,
    DPG_OP_CLR   = 2'b10
  } dpg_op_t;

endpackage

// *** testbench/dpg_gpio_chk_sva.sv ***
module dpg_gpio_chk
  import dpg_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        power_on,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [7:0]  first_port_pins_oe_n,
  input wire logic [7:0]  first_port_pins_out,
  input wire logic [7:0]  first_port_pullup_en,
  input wire logic [7:0]  third_port_data_oe_n,
  input wire logic        irq,
  input wire logic        wake
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  assign wr = psel && penable && pwrite && pstrb[0];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  first_dir_a: assert property (
    wr && paddr == {IDX_FIRST_DIR, 2'b00}
    |=> first_port_pins_oe_n == $past(pwdata[7:0]))
    else $error("first direction write lost");
  first_latch_a: assert property (
    wr && paddr == {IDX_FIRST_DATA, 2'b00}
    |=> first_port_pins_out == $past(pwdata[7:0]))
    else $error("first latch write lost");
  pullup_ctrl_a: assert property (
    wr && paddr == {IDX_OPTION, 2'b00} |=> first_port_pullup_en
    == (first_port_pins_oe_n & {8{~$past(pwdata[7])}}))
    else $error("pull-up control wrong");
  pullup_out_a: assert property (
    (first_port_pullup_en & ~first_port_pins_oe_n) == 8'h00)
    else $error("pull-up on a driven pin");
  irq_mask_a: assert property (
    wr && paddr == {IDX_IRQ_CTRL, 2'b00} && !pwdata[IRQ_EN_BIT]
    |=> !irq [*2])
    else $error("masked interrupt raised");
  wake_irq_a: assert property (
    $rose(irq) |-> wake)
    else $error("no wake with interrupt");
  wake_hold_a: assert property (
    $fell(wake) |-> $past(wr && paddr == {IDX_IRQ_CTRL, 2'b00}))
    else $error("wake dropped without a control write");
  por_pullup_a: assert property (disable iff (1'b0)
    !rst_n && power_on |=> first_port_pullup_en == 8'h00)
    else $error("pull-ups on after power-on");
  third_rst_a: assert property (disable iff (1'b0)
    !rst_n |=> third_port_data_oe_n == DIR_RST)
    else $error("third direction not reset");
endmodule

// *** testbench/dpg_gpio_test.sv ***
module dpg_gpio_test
  import dpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        power_on = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic        pready, pslverr, irq, wake;
  logic [7:0]  fin, fout, foe_n, fpu, tin, tout, toe_n;
  logic [7:0]  fx_en = 8'hff, fx = 8'h00, tx = 8'h00;
  logic [7:0]  d, w, m, lt;
  int          fail_count = 0, n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  dpg_gpio i_dut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .power_on(power_on),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_port_pins_in(fin),
    .first_port_pins_out(fout), .first_port_pins_oe_n(foe_n),
    .first_port_pullup_en(fpu), .third_port_data_in(tin),
    .third_port_data_out(tout), .third_port_data_oe_n(toe_n),
    .irq(irq), .wake(wake)
  );
  dpg_keypad_model i_fkey
  (
    .ref_clk(ref_clk), .oe_n(foe_n), .out(fout), .pullup_en(fpu),
    .ext_en(fx_en), .ext_val(fx), .pins(fin)
  );
  dpg_keypad_model i_tkey
  (
    .ref_clk(ref_clk), .oe_n(toe_n), .out(tout), .pullup_en(8'h00),
    .ext_en(toe_n), .ext_val(tx), .pins(tin)
  );
  function automatic logic [7:0] lvl(logic [7:0] l, dr, e);
    return (l & ~dr) | (e & dr);
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic bus(logic wr, logic [9:0] idx, logic [7:0] dat,
                     logic err = 1'b0);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, dat};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", {31'h0, err}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(string what, logic [9:0] idx, logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, {24'h000000, exp}, r);
  endtask
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(87849));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    power_on <= 1'b0;
    chk("pull-ups", 8'h00, fpu);
    rdc("option", IDX_OPTION, OPTION_RST);
    rdc("third dir", IDX_THIRD_DIR, DIR_RST);
    rdc("third latch", IDX_THIRD_SET, LATCH_POR);
    $display("Test reset done");
    for (int i = 0; i < 16; i++)
    begin
      d = 8'($urandom);
      w = 8'($urandom);
      m = 8'($urandom);
      if (i[0])
        tx <= m;
      else
      begin
        fx <= m;
        fx_en <= d;
      end
      bus(1'b1, i[0] ? IDX_THIRD_DIR : IDX_FIRST_DIR, d);
      bus(1'b1, i[0] ? IDX_THIRD_DATA : IDX_FIRST_DATA, w);
      repeat (3) @(posedge ref_clk);
      chk("dir", d, i[0] ? toe_n : foe_n);
      chk("latch", w, i[0] ? tout : fout);
      rdc("pins", i[0] ? IDX_THIRD_DATA : IDX_FIRST_DATA, lvl(w, d, m));
    end
    $display("Test ports done");
    fx_en <= 8'h00;
    bus(1'b1, IDX_FIRST_DIR, 8'h0f);
    bus(1'b1, IDX_FIRST_DATA, 8'h00);
    bus(1'b1, IDX_OPTION, 8'h7f);
    repeat (3) @(posedge ref_clk);
    chk("pull-up set", 8'h0f, fpu);
    rdc("pulled pins", IDX_FIRST_DATA, 8'h0f);
    fx_en <= 8'hff;
    bus(1'b1, IDX_OPTION, 8'hff);
    $display("Test pull-up done");
    fx <= 8'h00;
    bus(1'b1, IDX_FIRST_DIR, 8'hff);
    repeat (3) @(posedge ref_clk);
    bus(1'b0, IDX_FIRST_DATA, 8'h00);
    bus(1'b1, IDX_IRQ_CTRL, 8'h09);
    repeat (4) @(posedge ref_clk);
    chk("irq idle", 1'b0, irq);
    fx <= 8'h0f;
    repeat (4) @(posedge ref_clk);
    chk("irq low nibble", 1'b0, irq);
    fx <= 8'h4f;
    repeat (4) @(posedge ref_clk);
    chk("irq change", 1'b1, irq);
    chk("wake", 1'b1, wake);
    bus(1'b1, IDX_IRQ_CTRL, 8'h09);
    repeat (2) @(posedge ref_clk);
    chk("irq persists", 1'b1, irq);
    bus(1'b0, IDX_FIRST_DATA, 8'h00);
    bus(1'b1, IDX_IRQ_CTRL, 8'h09);
    repeat (2) @(posedge ref_clk);
    chk("irq cleared", 1'b0, irq);
    fx <= 8'h0f;
    bus(1'b1, IDX_IRQ_CTRL, 8'h00);
    repeat (4) @(posedge ref_clk);
    chk("irq masked", 1'b0, irq);
    rdc("flag held", IDX_IRQ_CTRL, 8'h01);
    bus(1'b1, IDX_FIRST_CLR, 8'h30);
    bus(1'b1, IDX_IRQ_CTRL, 8'h01);
    rdc("flag ended", IDX_IRQ_CTRL, 8'h00);
    chk("first clr", 8'h0f, fout);
    bus(1'b1, IDX_FIRST_SET, 8'h80);
    @(posedge ref_clk);
    chk("first set", 8'h8f, fout);
    bus(1'b0, 10'h3ff, 8'h00, 1'b1);
    $display("Test change done");
    bus(1'b1, IDX_THIRD_DIR, 8'h0f);
    lt = 8'($urandom);
    bus(1'b1, IDX_THIRD_DATA, lt);
    for (int i = 0; i < 4; i++)
    begin
      m = 8'($urandom);
      tx <= 8'($urandom);
      repeat (3) @(posedge ref_clk);
      lt = lvl(lt, 8'h0f, tx);
      lt = i[0] ? lt & ~m : lt | m;
      bus(1'b1, i[0] ? IDX_THIRD_CLR : IDX_THIRD_SET, m);
      @(posedge ref_clk);
      chk("rmw latch", lt, tout);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("kept latch", lt, tout);
    rdc("first dir", IDX_FIRST_DIR, DIR_RST);
    $display("Test rmw done");
    complete_run();
  end
endmodule
bind dpg_gpio dpg_gpio_chk i_chk
(
  .ref_clk(ref_clk), .rst_n(rst_n), .power_on(power_on), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .pstrb(pstrb), .first_port_pins_oe_n(first_port_pins_oe_n),
  .first_port_pins_out(first_port_pins_out),
  .first_port_pullup_en(first_port_pullup_en),
  .third_port_data_oe_n(third_port_data_oe_n), .irq(irq), .wake(wake)
);

// *** testbench/dpg_keypad_model.sv ***
module dpg_keypad_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] oe_n,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pullup_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] drift = 8'h5a;
  // Undriven lines wander so a stale level never reads as valid
  always @(posedge ref_clk)
    drift <= ~drift;
  always_comb
    for (int i = 0; i < 8; i++)
      pins[i] = !oe_n[i] ? out[i] : ext_en[i] ? ext_val[i] :
                pullup_en[i] ? 1'b1 : drift[i];
endmodule
